// ==== common/std_switch_defs.svh ====
// constants for the dynamic 1000BASE-X / SGMII standard switch
// assumes one 20 MHz system clock shared by both ends of the link
//
// Overview of operation
// - default select low: reset into 1000BASE-X
// - default select high: reset into SGMII
// - set default select, then reset to switch
// - register 17 write switches standard anytime
// - registers 0-16 reinterpret immediately after switch
// - negotiation follows currently selected standard procedure
// - register 17 switch during negotiation waits for its completion; the strap path aborts and restarts it
// - standard write never restarts negotiation itself
// - host rewrites advertisement after switching to 1000BASE-X; the host skips it on the strap path
// - host restarts negotiation after a register 17 switch; the strap path restarts it by soft reset
// - switching only between 1000BASE-X and 1G SGMII
// - attached MAC runs full duplex only
// - both ends share one clock domain
// - SGMII runs at 1G rate only
// - link timer 1.6 ms SGMII, 10 ms 1000BASE-X
`ifndef STD_SWITCH_DEFS_SVH
`define STD_SWITCH_DEFS_SVH

// ------------------------------------------------------------
// management register addresses
// ------------------------------------------------------------
`define REG_CTRL 5'h00
`define REG_STAT 5'h01
`define REG_ADV 5'h04
`define REG_STD 5'h11

// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define CTRL_AN_EN_BIT 12
`define CTRL_RESTART_BIT 9
`define STAT_AN_DONE_BIT 5
`define STAT_AN_ABLE_BIT 3
`define STD_SEL_BIT 0
`define ADV_RESET 16'h0020
`define ADV_SGMII 16'h0001
`define CTRL_AN_EN_RESET 1'b1

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS 50
`define LINK_TIMER_SGMII_NS 1600000
`define LINK_TIMER_BASEX_NS 10000000
`define LINK_TIMER_SGMII_CYC (`LINK_TIMER_SGMII_NS / `CLK_PERIOD_NS)
`define LINK_TIMER_BASEX_CYC (`LINK_TIMER_BASEX_NS / `CLK_PERIOD_NS)
`define LINK_TIMER_W 18

`endif

// ==== common/std_switch_if.sv ====
// management link between the PCS control end and the MAC side end
// assumes both ends run on the same system clock
`timescale 1ns/1ns
`default_nettype none

interface std_switch_if;
  logic wr_en;
  logic rd_en;
  logic [4:0] addr;
  logic [15:0] wdata;
  logic default_sel;
  logic std_reset;
  logic [15:0] rdata;
  logic rd_valid;
  logic link_sgmii;
  logic an_busy;
  logic an_done;

  modport device (
    input wr_en, rd_en, addr, wdata, default_sel, std_reset,
    output rdata, rd_valid, link_sgmii, an_busy, an_done
  );

  modport host (
    output wr_en, rd_en, addr, wdata, default_sel, std_reset,
    input rdata, rd_valid, link_sgmii, an_busy, an_done
  );
endinterface

`default_nettype wire

// ==== common/std_switch_pkg.sv ====
// types shared by both ends of the standard switch link
// assumes std_switch_defs.svh is on the include path
package std_switch_pkg;

  typedef enum logic [0:0] {
    STD_BASEX = 1'b0,
    STD_SGMII = 1'b1
  } std_type;

  typedef enum logic [1:0] {
    AN_IDLE = 2'b00,
    AN_RUN = 2'b01,
    AN_DONE = 2'b10
  } an_state_type;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_WR_STD = 3'b001,
    HS_WR_ADV = 3'b010,
    HS_WR_RESTART = 3'b011,
    HS_STRAP_RESET = 3'b100
  } host_state_type;

endpackage

// ==== design/an_link_timer.sv ====
// auto-negotiation link timer with a per-standard duration
// assumes start_i is a one-cycle pulse on the system clock
`timescale 1ns/1ns
`default_nettype none
`include "std_switch_defs.svh"

module an_link_timer #(
  parameter logic [`LINK_TIMER_W-1:0] SGMII_CYC = `LINK_TIMER_W'(`LINK_TIMER_SGMII_CYC),
  parameter logic [`LINK_TIMER_W-1:0] BASEX_CYC = `LINK_TIMER_W'(`LINK_TIMER_BASEX_CYC)
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic start_i,
  input wire logic sgmii_i,
  output logic expired_o
);

  logic [`LINK_TIMER_W-1:0] count_r;
  logic running_r;
  wire [`LINK_TIMER_W-1:0] load_val = sgmii_i ? SGMII_CYC : BASEX_CYC;
  wire last_tick = running_r && (count_r == `LINK_TIMER_W'(1));

  // ------------------------------------------------------------
  // count down; a new start reloads even while running
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_r <= '0;
      running_r <= 1'b0;
      expired_o <= 1'b0;
    end else begin
      expired_o <= last_tick && !start_i;
      if (start_i) begin
        count_r <= load_val;
        running_r <= 1'b1;
      end else if (running_r) begin
        count_r <= count_r - `LINK_TIMER_W'(1);
        running_r <= !last_tick;
      end
    end
  end

endmodule

`default_nettype wire

// ==== design/std_switch_device.sv ====
// PCS standard-switch control: standard selection, management registers
// 0, 1, 4 and 17, and auto-negotiation sequencing with its link timer
// assumes the management party and the MAC share clk_sys_i with this block
`timescale 1ns/1ns
`default_nettype none
`include "std_switch_defs.svh"

module std_switch_device
  import std_switch_pkg::*;
#(
  parameter logic [`LINK_TIMER_W-1:0] SGMII_CYC = `LINK_TIMER_W'(`LINK_TIMER_SGMII_CYC),
  parameter logic [`LINK_TIMER_W-1:0] BASEX_CYC = `LINK_TIMER_W'(`LINK_TIMER_BASEX_CYC)
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  std_switch_if.device link,
  output logic std_sgmii_o,
  output logic an_complete_o,
  output logic rate_2g5_o
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  std_type std_r; // standard seen by the management registers
  std_type std_nxt;
  std_type eff_std_r; // standard the negotiation is running under
  std_type eff_std_nxt;
  an_state_type an_r;
  an_state_type an_nxt;
  logic init_r; // strap sample pending after a reset
  logic an_en_r;
  logic [15:0] adv_r;
  logic [15:0] rdata_r;
  logic rd_valid_r;
  logic an_busy_r;
  logic an_done_r;
  logic timer_expired;

  // ------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------
  wire wr_ctrl = link.wr_en && (link.addr == `REG_CTRL);
  wire wr_adv = link.wr_en && (link.addr == `REG_ADV);
  wire wr_std = link.wr_en && (link.addr == `REG_STD);
  wire restart_req = wr_ctrl && link.wdata[`CTRL_RESTART_BIT];
  wire an_en_nxt = wr_ctrl ? link.wdata[`CTRL_AN_EN_BIT] : an_en_r;
  // only the one select bit exists; no 2.5G standard can be chosen
  wire std_wr_val = link.wdata[`STD_SEL_BIT];
  // the strap is read on the first edge after either reset form
  wire strap_take = init_r || link.std_reset;
  wire strap_std = link.default_sel;
  // sequence starts after reset or on an explicit restart only
  wire an_start = an_en_nxt && (restart_req || init_r);

  // ------------------------------------------------------------
  // standard selection
  // ------------------------------------------------------------
  always_comb begin
    std_nxt = std_r;
    if (strap_take) begin
      std_nxt = std_type'(strap_std);
    end else if (wr_std) begin
      std_nxt = std_type'(std_wr_val);
    end
  end

  // negotiation keeps the standard it started under until it ends
  assign eff_std_nxt = (an_r == AN_RUN && !strap_take) ? eff_std_r : std_nxt;

  // ------------------------------------------------------------
  // negotiation sequence
  // ------------------------------------------------------------
  always_comb begin
    an_nxt = an_r;
    if (link.std_reset) begin
      an_nxt = AN_IDLE;
    end else if (an_start) begin
      an_nxt = AN_RUN;
    end else begin
      unique case (an_r)
        AN_IDLE: an_nxt = AN_IDLE;
        AN_RUN: if (timer_expired) begin
          an_nxt = AN_DONE;
        end
        AN_DONE: an_nxt = AN_DONE;
        default: an_nxt = AN_IDLE;
      endcase
    end
  end

  an_link_timer #(
    .SGMII_CYC(SGMII_CYC),
    .BASEX_CYC(BASEX_CYC)
  ) u_timer (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .start_i(an_start && !link.std_reset),
    .sgmii_i(eff_std_nxt == STD_SGMII),
    .expired_o(timer_expired)
  );

  // ------------------------------------------------------------
  // register read view; layout follows the standard at once
  // ------------------------------------------------------------
  wire [15:0] ctrl_view = 16'(an_en_r) << `CTRL_AN_EN_BIT;
  wire [15:0] stat_view = (16'(an_r == AN_DONE) << `STAT_AN_DONE_BIT) | (16'h0001 << `STAT_AN_ABLE_BIT);
  // sgmii mac mode advertises a fixed word instead of the stored one
  wire [15:0] adv_view = (std_r == STD_SGMII) ? `ADV_SGMII : adv_r;
  wire [15:0] std_view = 16'(std_r) << `STD_SEL_BIT;
  logic [15:0] rd_mux;

  always_comb begin
    rd_mux = 16'h0000;
    if (link.addr == `REG_CTRL) rd_mux = ctrl_view;
    if (link.addr == `REG_STAT) rd_mux = stat_view;
    if (link.addr == `REG_ADV) rd_mux = adv_view;
    if (link.addr == `REG_STD) rd_mux = std_view;
  end

  // ------------------------------------------------------------
  // control flops; reset lands in 1000BASE-X until the strap is taken
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      std_r <= STD_BASEX;
      eff_std_r <= STD_BASEX;
      an_r <= AN_IDLE;
      init_r <= 1'b1;
      an_en_r <= `CTRL_AN_EN_RESET;
    end else begin
      std_r <= std_nxt;
      eff_std_r <= eff_std_nxt;
      an_r <= an_nxt;
      init_r <= link.std_reset;
      an_en_r <= link.std_reset ? `CTRL_AN_EN_RESET : an_en_nxt;
    end
  end

  // advertisement kept separately; soft reset restores it
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      adv_r <= `ADV_RESET;
    end else if (link.std_reset) begin
      adv_r <= `ADV_RESET;
    end else if (wr_adv) begin
      adv_r <= link.wdata;
    end
  end

  // ------------------------------------------------------------
  // registered answers and status outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_r <= 16'h0000;
      rd_valid_r <= 1'b0;
      an_busy_r <= 1'b0;
      an_done_r <= 1'b0;
      std_sgmii_o <= 1'b0;
      an_complete_o <= 1'b0;
      rate_2g5_o <= 1'b0;
    end else begin
      rdata_r <= link.rd_en ? rd_mux : 16'h0000;
      rd_valid_r <= link.rd_en;
      an_busy_r <= (an_nxt == AN_RUN);
      an_done_r <= (an_nxt == AN_DONE);
      std_sgmii_o <= (eff_std_nxt == STD_SGMII);
      an_complete_o <= (an_nxt == AN_DONE);
      rate_2g5_o <= 1'b0;
    end
  end

  assign link.rdata = rdata_r;
  assign link.rd_valid = rd_valid_r;
  assign link.link_sgmii = std_sgmii_o;
  assign link.an_busy = an_busy_r;
  assign link.an_done = an_done_r;

endmodule

`default_nettype wire

// ==== design/std_switch_host.sv ====
// MAC-side management end: issues standard switches by register write
// or by strap plus soft reset, and follows a register-write switch with the recommended writes
// assumes the PCS end answers on the same system clock
`timescale 1ns/1ns
`default_nettype none
`include "std_switch_defs.svh"

module std_switch_host
  import std_switch_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  std_switch_if.host link,
  input wire logic switch_i,
  input wire logic strap_switch_i,
  input wire logic sgmii_sel_i,
  input wire logic [15:0] adv_i,
  output logic busy_o,
  output logic full_duplex_o,
  output logic sgmii_o
);

  host_state_type st_r;
  host_state_type st_nxt;
  logic target_r;
  logic [15:0] adv_r;
  logic strap_r;
  logic wr_en_r;
  logic [4:0] addr_r;
  logic [15:0] wdata_r;
  logic std_reset_r;

  wire idle = (st_r == HS_IDLE);

  // ------------------------------------------------------------
  // sequence: standard write, optional advertisement, restart
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      HS_IDLE: begin
        if (strap_switch_i) st_nxt = HS_STRAP_RESET;
        else if (switch_i) st_nxt = HS_WR_STD;
      end
      HS_WR_STD: st_nxt = target_r ? HS_WR_RESTART : HS_WR_ADV;
      HS_WR_ADV: st_nxt = HS_WR_RESTART;
      HS_WR_RESTART: st_nxt = HS_IDLE;
      HS_STRAP_RESET: st_nxt = HS_IDLE;
      default: st_nxt = HS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= HS_IDLE;
      target_r <= 1'b0;
      adv_r <= `ADV_RESET;
      strap_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (idle && (switch_i || strap_switch_i)) begin
        target_r <= sgmii_sel_i;
        adv_r <= adv_i;
      end
      // strap level is set first so it stands before the reset pulse
      if (idle && strap_switch_i) strap_r <= sgmii_sel_i;
    end
  end

  // ------------------------------------------------------------
  // drive the link from flops; one write per cycle
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_en_r <= 1'b0;
      addr_r <= 5'h00;
      wdata_r <= 16'h0000;
      std_reset_r <= 1'b0;
    end else begin
      wr_en_r <= (st_nxt == HS_WR_STD) || (st_nxt == HS_WR_ADV) || (st_nxt == HS_WR_RESTART);
      std_reset_r <= (st_r == HS_STRAP_RESET);
      unique case (st_nxt)
        HS_WR_STD: begin
          addr_r <= `REG_STD;
          wdata_r <= 16'(idle ? sgmii_sel_i : target_r) << `STD_SEL_BIT;
        end
        HS_WR_ADV: begin
          addr_r <= `REG_ADV;
          wdata_r <= adv_r;
        end
        HS_WR_RESTART: begin
          addr_r <= `REG_CTRL;
          wdata_r <= (16'h0001 << `CTRL_AN_EN_BIT) | (16'h0001 << `CTRL_RESTART_BIT);
        end
        default: begin
          addr_r <= 5'h00;
          wdata_r <= 16'h0000;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // user-side status
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_o <= 1'b0;
      full_duplex_o <= 1'b0;
      sgmii_o <= 1'b0;
    end else begin
      busy_o <= (st_nxt != HS_IDLE) || std_reset_r;
      full_duplex_o <= 1'b1;
      sgmii_o <= link.link_sgmii;
    end
  end

  assign link.wr_en = wr_en_r;
  assign link.rd_en = 1'b0;
  assign link.addr = addr_r;
  assign link.wdata = wdata_r;
  assign link.default_sel = strap_r;
  assign link.std_reset = std_reset_r;

endmodule

`default_nettype wire

// ==== verif/std_switch_sva.sv ====
// assertions on the management link between host end and device end
// assumes one system clock and an active-low asynchronous reset
`timescale 1ns/1ns
`default_nettype none

module std_switch_sva #(
  parameter int SGMII_CYC = 20,
  parameter int BASEX_CYC = 50
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic wr_en,
  input wire logic [4:0] addr,
  input wire logic [15:0] wdata,
  input wire logic default_sel,
  input wire logic std_reset,
  input wire logic link_sgmii,
  input wire logic an_busy,
  input wire logic an_done
);
  int busy_cnt_r;
  int run_len;

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  // ------------------------------------------------------------
  // helper logic
  // ------------------------------------------------------------
  // a restart in mid-run would stretch the count; every run is judged when an_busy falls
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_cnt_r <= 0;
    end else begin
      busy_cnt_r <= an_busy ? busy_cnt_r + 1 : 0;
    end
  end
  assign run_len = link_sgmii ? SGMII_CYC : BASEX_CYC;

  sequence s_std_write;
    wr_en && addr == 5'h11 && !an_busy;
  endsequence
  sequence s_restart;
    wr_en && addr == 5'h00 && wdata[9] && wdata[12];
  endsequence

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  a_strap_basex: assert property (std_reset && !default_sel |-> ##[1:6] (an_busy && !link_sgmii))
    else $error("strap low did not select 1000base-x");
  a_strap_sgmii: assert property (std_reset && default_sel |-> ##[1:6] (an_busy && link_sgmii))
    else $error("strap high did not select sgmii");
  a_std_write: assert property (s_std_write |-> ##2 (link_sgmii == $past(wdata[0], 2)))
    else $error("standard write not adopted");
  a_write_no_an: assert property (s_std_write |=> !an_busy)
    else $error("standard write started negotiation");
  a_restart_runs: assert property (s_restart |-> ##[1:2] an_busy)
    else $error("restart did not start negotiation");
  a_run_length: assert property ($fell(an_busy) |-> busy_cnt_r >= run_len - 2 && busy_cnt_r <= run_len + 2)
    else $error("link timer length wrong for standard");
  a_frozen_std: assert property (an_busy && $past(an_busy) |-> $stable(link_sgmii))
    else $error("standard changed during negotiation");
  a_done_at_end: assert property ($fell(an_busy) |-> an_done)
    else $error("negotiation ended without done");
endmodule

`default_nettype wire

// ==== verif/test_dynamic_standard_switch.sv ====
// bench: host end joined to a device end, plus a second device driven here
// assumes the design header is on the include path
`timescale 1ns/1ns
`default_nettype none
`include "std_switch_defs.svh"

module test_dynamic_standard_switch;
  localparam int SGMII_N = 20;
  localparam int BASEX_N = 50;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic switch_i = 1'b0;
  logic strap_switch_i = 1'b0;
  logic sgmii_sel_i = 1'b0;
  logic [15:0] adv_i = 16'h01A0;
  logic busy_o, full_duplex_o, sgmii_o, std_sgmii_a, an_complete_a, rate_a, std_sgmii_b, an_complete_b, rate_b;
  logic [15:0] adv_seen;
  int rst_cnt;
  int fails = 0;
  int tests_run = 0;
  // per step: bit1 strap path, bit0 target standard
  logic [1:0] steps [4] = '{2'b01, 2'b10, 2'b11, 2'b00};

  std_switch_if link_a ();
  std_switch_if link_b ();

  // ------------------------------------------------------------
  // clock and ends under test
  // ------------------------------------------------------------
  always #25 clk_sys_i = ~clk_sys_i;

  std_switch_host std_switch_host_inst (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .link(link_a.host),
    .switch_i(switch_i), .strap_switch_i(strap_switch_i), .sgmii_sel_i(sgmii_sel_i), .adv_i(adv_i),
    .busy_o(busy_o), .full_duplex_o(full_duplex_o), .sgmii_o(sgmii_o));
  std_switch_device #(.SGMII_CYC(`LINK_TIMER_W'(SGMII_N)), .BASEX_CYC(`LINK_TIMER_W'(BASEX_N)))
    std_switch_device_inst (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .link(link_a.device),
    .std_sgmii_o(std_sgmii_a), .an_complete_o(an_complete_a), .rate_2g5_o(rate_a));
  // second device: the bench stands in for the host end here
  std_switch_device #(.SGMII_CYC(`LINK_TIMER_W'(SGMII_N)), .BASEX_CYC(`LINK_TIMER_W'(BASEX_N)))
    std_switch_device_inst_b (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .link(link_b.device),
    .std_sgmii_o(std_sgmii_b), .an_complete_o(an_complete_b), .rate_2g5_o(rate_b));
  std_switch_sva #(.SGMII_CYC(SGMII_N), .BASEX_CYC(BASEX_N)) std_switch_sva_inst (.clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i), .wr_en(link_a.wr_en), .addr(link_a.addr), .wdata(link_a.wdata),
    .default_sel(link_a.default_sel), .std_reset(link_a.std_reset), .link_sgmii(link_a.link_sgmii),
    .an_busy(link_a.an_busy), .an_done(link_a.an_done));

  // wire monitor: advertisement rewrites and restarts issued by the host end
  always @(posedge clk_sys_i) begin
    if (link_a.wr_en && link_a.addr == `REG_ADV) adv_seen <= link_a.wdata;
    if (link_a.wr_en && link_a.addr == `REG_CTRL && link_a.wdata[`CTRL_RESTART_BIT]) rst_cnt <= rst_cnt + 1;
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  function automatic logic busy_of(input bit on_b);
    return on_b ? link_b.an_busy : link_a.an_busy;
  endfunction

  // a run already going counts as started; both waits are bounded
  task automatic wait_an(input bit on_b);
    int n;
    int m;
    for (n = 0; n < 20 && busy_of(on_b) !== 1'b1; n++) @(negedge clk_sys_i);
    for (m = 0; m < 200 && busy_of(on_b) !== 1'b0; m++) @(negedge clk_sys_i);
    if (n == 20 || m == 200) begin
      fails++;
      print_verdict();
    end
  endtask

  task automatic host_req(input logic strap, input logic sel);
    @(negedge clk_sys_i);
    adv_seen = 16'hFFFF;
    rst_cnt = 0;
    sgmii_sel_i = sel;
    switch_i = !strap;
    strap_switch_i = strap;
    @(negedge clk_sys_i);
    switch_i = 1'b0;
    strap_switch_i = 1'b0;
    check(16'(busy_o), 16'h0001);
    wait_an(1'b0);
    check(16'({link_a.link_sgmii, sgmii_o, std_sgmii_a}), sel ? 16'h0007 : 16'h0000);
    check(16'({busy_o, an_complete_a}), 16'h0001);
    check(adv_seen, (strap || sel) ? 16'hFFFF : adv_i);
    check(16'(rst_cnt), strap ? 16'h0000 : 16'h0001);
  endtask

  // released lines carry the inverse so a stale value is never mistaken for data
  task automatic wr_b(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk_sys_i);
    link_b.wr_en = 1'b1;
    link_b.addr = a;
    link_b.wdata = d;
    @(negedge clk_sys_i);
    link_b.wr_en = 1'b0;
    link_b.addr = ~a;
    link_b.wdata = ~d;
  endtask

  task automatic rd_b(input logic [4:0] a, input logic [15:0] exp);
    @(negedge clk_sys_i);
    link_b.rd_en = 1'b1;
    link_b.addr = a;
    @(negedge clk_sys_i);
    link_b.rd_en = 1'b0;
    link_b.addr = ~a;
    check(link_b.rd_valid ? link_b.rdata : 16'hDEAD, exp);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    link_b.wr_en = 1'b0;
    link_b.rd_en = 1'b0;
    link_b.addr = 5'h00;
    link_b.wdata = 16'h0000;
    link_b.default_sel = 1'b1;
    link_b.std_reset = 1'b0;
    repeat (16) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    resetn_i = 1'b1;
    wait_an(1'b1);
    wait_an(1'b0);
    check(16'(link_a.link_sgmii), 16'h0000);
    check(16'(link_b.link_sgmii), 16'h0001);
    check(16'({full_duplex_o, rate_a, rate_b}), 16'h0004);
    rd_b(`REG_ADV, `ADV_SGMII);
    for (int i = 0; i < 4; i++) host_req(steps[i][1], steps[i][0]);
    wr_b(`REG_STD, 16'h0000);
    repeat (2) @(negedge clk_sys_i);
    check(16'({link_b.link_sgmii, link_b.an_busy}), 16'h0000);
    rd_b(`REG_ADV, `ADV_RESET);
    rd_b(`REG_STD, 16'h0000);
    rd_b(5'h1F, 16'h0000);
    wr_b(`REG_CTRL, 16'h1200);
    wr_b(`REG_STD, 16'h0001);
    rd_b(`REG_ADV, `ADV_SGMII);
    check(16'({link_b.link_sgmii, link_b.an_busy}), 16'h0001);
    wait_an(1'b1);
    repeat (2) @(negedge clk_sys_i);
    check(16'({link_b.link_sgmii, an_complete_b, rate_b}), 16'h0006);
    link_b.default_sel = 1'b0;
    @(negedge clk_sys_i);
    link_b.std_reset = 1'b1;
    @(negedge clk_sys_i);
    link_b.std_reset = 1'b0;
    wait_an(1'b1);
    check(16'({link_b.link_sgmii, std_sgmii_b}), 16'h0000);
    print_verdict();
  end
endmodule

`default_nettype wire
